// file: hdl/digital_phase_loop_div_pkg.sv
// Constants shared by the reference and feedback divider block.
// Assumes a single 25 MHz system clock and AXI4-Lite register access.
package digital_phase_loop_div_pkg;

    // ****************************************************************
    // Register indices; byte address is four times the index.
    // ****************************************************************
    localparam logic [11:0] REF_DIV_LOW_IDX   = 12'h101;
    localparam logic [11:0] REF_DIV_HIGH_IDX  = 12'h102;
    localparam logic [11:0] REF_DIV_CTRL_IDX  = 12'h103;
    localparam logic [11:0] FB_DIV_LOW_IDX    = 12'h104;
    localparam logic [11:0] FB_DIV_HIGH_IDX   = 12'h105;
    localparam logic [11:0] FB_DIV_CTRL_IDX   = 12'h106;
    localparam logic [11:0] REF_SELECT_IDX    = 12'h180;
    localparam logic [11:0] DIV_STATUS_IDX    = 12'h181;

    // ****************************************************************
    // Field positions and reset values.
    // ****************************************************************
    localparam int          CTRL_PRESCALE_BIT = 0;
    localparam int          CTRL_INVERT_BIT   = 7;
    localparam logic [7:0]  BYTE_RESET        = 8'h00;
    localparam logic [7:0]  CTRL_RW_MASK      = 8'h81;
    localparam int          STAT_REF_LVL_BIT  = 0;
    localparam int          STAT_FB_LVL_BIT   = 1;
    localparam int          STAT_REF_CNT_LSB  = 8;
    localparam int          STAT_FB_CNT_LSB   = 16;

    // ****************************************************************
    // Bus response codes.
    // ****************************************************************
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

endpackage

// file: hdl/edge_divider.sv
// One programmable edge divider with optional inversion and /2 prescaler.
// Assumes clk_pin is asynchronous to clk and slower than half its rate.
module edge_divider #(
    parameter int RATIO_W = 16
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Input pin
    input  wire logic               clk_pin,
    // Settings
    input  wire logic               invert,
    input  wire logic               prescale,
    input  wire logic [RATIO_W-1:0] ratio,
    // Results
    output logic                    div_event,
    output logic                    div_level
);

    logic               sync1_ff;
    logic               sync2_ff;
    logic               prev_ff;
    logic               half_ff;
    logic [RATIO_W-1:0] count_ff;
    logic               edge_seen;
    logic               counted;

    // ****************************************************************
    // Synchroniser and edge detection.
    // ****************************************************************
    always_ff @(posedge clk) begin
        sync1_ff <= clk_pin;
        sync2_ff <= sync1_ff;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= sync2_ff ^ invert; // R5 R10
        end
    end

    assign edge_seen = (sync2_ff ^ invert) && !prev_ff; // R5 R10

    // ****************************************************************
    // Prescaler and main counter.
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            half_ff <= 1'b0;
        end else if (edge_seen && prescale) begin
            half_ff <= !half_ff; // R4 R10
        end
    end

    assign counted = edge_seen && (!prescale || half_ff); // R4 R10

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_ff  <= '0;
            div_event <= 1'b0;
            div_level <= 1'b0;
        end else begin
            div_event <= 1'b0;
            if (counted) begin
                if (count_ff >= ratio) begin
                    count_ff  <= '0; // R1 R6 R11
                    div_event <= 1'b1; // R11
                    div_level <= !div_level;
                end else begin
                    count_ff <= count_ff + 1'b1;
                end
            end
        end
    end

endmodule

// file: hdl/digital_phase_loop_ref_feedback_dividers.sv
// Reference and feedback input dividers with an AXI4-Lite register file.
// Assumes input pins are asynchronous and toggle below half the aclk rate.
//
// Contract
// R1 - Reference divides by programmed 16-bit value plus one, 1 to 65,536.
// R2 - Reference value spans two bytes, low at 0x0101; zeros divide by one.
// R3 - Host sets reference prescaler above ratio 65,536 or 400 MHz input.
// R4 - Reference prescaler bit adds a divide-by-two stage before the divider.
// R5 - Reference control bit 7 inverts the reference so falling edges count.
// R6 - Feedback divides by programmed 16-bit value plus one, 1 to 65,536.
// R7 - Feedback value spans two bytes, low at 0x0104; zeros divide by one.
// R8 - Host sets feedback prescaler in 0x0106 above 65,536 or 400 MHz.
// R9 - Reference control bits 6 to 1 are reserved and do nothing.
// R10 - Feedback control bit 7 inverts, bit 0 adds divide-by-two prescaler.
// R11 - Each divider emits one event per N counted edges, N the total ratio.
//
// Design decision made here: the AXI4-Lite interface to the registers.
module digital_phase_loop_ref_feedback_dividers #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Clock inputs
    input  wire logic              reference_input_first,
    input  wire logic              reference_input_second,
    input  wire logic              feedback_clock_input,
    // Divided outputs
    output logic                   ref_div_event,
    output logic                   ref_div_clock,
    output logic                   fb_div_event,
    output logic                   fb_div_clock
);

    logic [7:0]        ref_low_ff;
    logic [7:0]        ref_high_ff;
    logic [7:0]        ref_ctrl_ff;
    logic [7:0]        fb_low_ff;
    logic [7:0]        fb_high_ff;
    logic [7:0]        fb_ctrl_ff;
    logic              ref_sel_ff;
    logic [7:0]        ref_cnt_ff;
    logic [7:0]        fb_cnt_ff;
    logic              aw_held_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic              w_held_ff;
    logic [7:0]        w_byte_ff;
    logic              w_lane_ff;
    logic              commit;
    logic [11:0]       wr_idx;
    logic [11:0]       rd_idx;
    logic [31:0]       nxt_rdata;
    logic              rd_hit;
    logic              wr_hit;
    logic              ref_pin;

    // ****************************************************************
    // Write channel handshakes.
    // ****************************************************************
    assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
    assign commit        = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign wr_idx        = 12'(aw_addr_ff >> 2);

    always_comb begin
        unique case (wr_idx)
            digital_phase_loop_div_pkg::REF_DIV_LOW_IDX,
            digital_phase_loop_div_pkg::REF_DIV_HIGH_IDX,
            digital_phase_loop_div_pkg::REF_DIV_CTRL_IDX,
            digital_phase_loop_div_pkg::FB_DIV_LOW_IDX,
            digital_phase_loop_div_pkg::FB_DIV_HIGH_IDX,
            digital_phase_loop_div_pkg::FB_DIV_CTRL_IDX,
            digital_phase_loop_div_pkg::REF_SELECT_IDX,
            digital_phase_loop_div_pkg::DIV_STATUS_IDX: wr_hit = 1'b1;
            default:                      wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
        end else if (commit) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff <= 1'b0;
            w_byte_ff <= digital_phase_loop_div_pkg::BYTE_RESET;
            w_lane_ff <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            w_byte_ff <= s_axi_wdata[7:0];
            w_lane_ff <= s_axi_wstrb[0];
        end else if (commit) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= digital_phase_loop_div_pkg::RESP_OKAY;
        end else if (commit) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? digital_phase_loop_div_pkg::RESP_OKAY : digital_phase_loop_div_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Register storage.
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_low_ff  <= digital_phase_loop_div_pkg::BYTE_RESET;
            ref_high_ff <= digital_phase_loop_div_pkg::BYTE_RESET;
            ref_ctrl_ff <= digital_phase_loop_div_pkg::BYTE_RESET;
            fb_low_ff   <= digital_phase_loop_div_pkg::BYTE_RESET;
            fb_high_ff  <= digital_phase_loop_div_pkg::BYTE_RESET;
            fb_ctrl_ff  <= digital_phase_loop_div_pkg::BYTE_RESET;
            ref_sel_ff  <= 1'b0;
        end else if (commit && w_lane_ff) begin
            unique case (wr_idx)
                digital_phase_loop_div_pkg::REF_DIV_LOW_IDX:  ref_low_ff  <= w_byte_ff; // R2
                digital_phase_loop_div_pkg::REF_DIV_HIGH_IDX: ref_high_ff <= w_byte_ff; // R2
                digital_phase_loop_div_pkg::REF_DIV_CTRL_IDX: ref_ctrl_ff <= w_byte_ff & digital_phase_loop_div_pkg::CTRL_RW_MASK; // R9
                digital_phase_loop_div_pkg::FB_DIV_LOW_IDX:   fb_low_ff   <= w_byte_ff; // R7
                digital_phase_loop_div_pkg::FB_DIV_HIGH_IDX:  fb_high_ff  <= w_byte_ff; // R7
                digital_phase_loop_div_pkg::FB_DIV_CTRL_IDX:  fb_ctrl_ff  <= w_byte_ff & digital_phase_loop_div_pkg::CTRL_RW_MASK; // R10
                digital_phase_loop_div_pkg::REF_SELECT_IDX:   ref_sel_ff  <= w_byte_ff[0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Read channel.
    // ****************************************************************
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx        = 12'(s_axi_araddr >> 2);

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        rd_hit    = 1'b1;
        unique case (rd_idx)
            digital_phase_loop_div_pkg::REF_DIV_LOW_IDX:  nxt_rdata[7:0] = ref_low_ff;
            digital_phase_loop_div_pkg::REF_DIV_HIGH_IDX: nxt_rdata[7:0] = ref_high_ff;
            digital_phase_loop_div_pkg::REF_DIV_CTRL_IDX: nxt_rdata[7:0] = ref_ctrl_ff;
            digital_phase_loop_div_pkg::FB_DIV_LOW_IDX:   nxt_rdata[7:0] = fb_low_ff;
            digital_phase_loop_div_pkg::FB_DIV_HIGH_IDX:  nxt_rdata[7:0] = fb_high_ff;
            digital_phase_loop_div_pkg::FB_DIV_CTRL_IDX:  nxt_rdata[7:0] = fb_ctrl_ff;
            digital_phase_loop_div_pkg::REF_SELECT_IDX:   nxt_rdata[0]   = ref_sel_ff;
            digital_phase_loop_div_pkg::DIV_STATUS_IDX: begin
                nxt_rdata[digital_phase_loop_div_pkg::STAT_REF_LVL_BIT]                             = ref_div_clock;
                nxt_rdata[digital_phase_loop_div_pkg::STAT_FB_LVL_BIT]                              = fb_div_clock;
                nxt_rdata[digital_phase_loop_div_pkg::STAT_REF_CNT_LSB +: 8]                        = ref_cnt_ff;
                nxt_rdata[digital_phase_loop_div_pkg::STAT_FB_CNT_LSB +: 8]                         = fb_cnt_ff;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= digital_phase_loop_div_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= nxt_rdata;
            s_axi_rresp  <= rd_hit ? digital_phase_loop_div_pkg::RESP_OKAY : digital_phase_loop_div_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Dividers and event counters.
    // ****************************************************************
    assign ref_pin = ref_sel_ff ? reference_input_second : reference_input_first;

    edge_divider #(
        .RATIO_W (16)
    ) u_ref_div (
        .clk       (aclk),
        .rst_n     (aresetn),
        .clk_pin   (ref_pin),
        .invert    (ref_ctrl_ff[digital_phase_loop_div_pkg::CTRL_INVERT_BIT]), // R5
        .prescale  (ref_ctrl_ff[digital_phase_loop_div_pkg::CTRL_PRESCALE_BIT]), // R4
        .ratio     ({ref_high_ff, ref_low_ff}), // R1 R2
        .div_event (ref_div_event),
        .div_level (ref_div_clock)
    );

    edge_divider #(
        .RATIO_W (16)
    ) u_fb_div (
        .clk       (aclk),
        .rst_n     (aresetn),
        .clk_pin   (feedback_clock_input),
        .invert    (fb_ctrl_ff[digital_phase_loop_div_pkg::CTRL_INVERT_BIT]), // R10
        .prescale  (fb_ctrl_ff[digital_phase_loop_div_pkg::CTRL_PRESCALE_BIT]), // R10
        .ratio     ({fb_high_ff, fb_low_ff}), // R6 R7
        .div_event (fb_div_event),
        .div_level (fb_div_clock)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_cnt_ff <= 8'h00;
            fb_cnt_ff  <= 8'h00;
        end else begin
            if (ref_div_event) begin
                ref_cnt_ff <= ref_cnt_ff + 8'h01;
            end
            if (fb_div_event) begin
                fb_cnt_ff <= fb_cnt_ff + 8'h01;
            end
        end
    end

endmodule

// file: tb/digital_phase_loop_div_asserts.sv
// Checker for the divider block's bus handshakes and divided outputs.
// Assumes it is bound to every instance of the top module.
module digital_phase_loop_div_asserts (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Divided outputs
    input wire logic ref_div_event,
    input wire logic ref_div_clock,
    input wire logic fb_div_event,
    input wire logic fb_div_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_ref_pulse; ref_div_event |=> !ref_div_event; endproperty
    a_ref_pulse: assert property (p_ref_pulse) else $error("ref event too long");
    property p_fb_pulse; fb_div_event |=> !fb_div_event; endproperty
    a_fb_pulse: assert property (p_fb_pulse) else $error("fb event too long");
    property p_ref_tgl; ref_div_clock != $past(ref_div_clock) |-> ref_div_event || $past(ref_div_event); endproperty
    a_ref_tgl: assert property (p_ref_tgl) else $error("ref clock moved without event");
    property p_fb_tgl; fb_div_clock != $past(fb_div_clock) |-> fb_div_event || $past(fb_div_event); endproperty
    a_fb_tgl: assert property (p_fb_tgl) else $error("fb clock moved without event");
    property p_b_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write response late");
    property p_b_ref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_b_ref: assert property (p_b_ref) else $error("write taken during response");
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_done: assert property (p_b_done) else $error("write response repeated");
    property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read data late");
    property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
    a_r_done: assert property (p_r_done) else $error("read data repeated");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_ref: cover property (ref_div_event);
    c_fb: cover property (fb_div_event);
endmodule
bind digital_phase_loop_ref_feedback_dividers digital_phase_loop_div_asserts chk_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ref_div_event(ref_div_event),
    .ref_div_clock(ref_div_clock), .fb_div_event(fb_div_event), .fb_div_clock(fb_div_clock)
);

// file: tb/clock_pin_model.sv
// Model of the reference and feedback clock sources.
// Assumes bursts are started by the bench; pins stand low between bursts.
module clock_pin_model (
    // Clock
    input wire logic aclk,
    // Clock pins
    output logic     reference_input_first,
    output logic     feedback_clock_input,
    output logic     reference_input_second
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] pin_ff = 3'h0;
    assign reference_input_first = pin_ff[0];
    assign feedback_clock_input = pin_ff[1];
    assign reference_input_second = pin_ff[2];
    task automatic set_pin(input int which, input logic v);
        @(posedge aclk);
        pin_ff[which] <= v;
    endtask
    // Each level stands for half cycles, two at the least.
    task automatic pulses(input int which, input int n, input int half);
        repeat (n) begin
            set_pin(which, 1'b1);
            repeat (half - 1) @(posedge aclk);
            set_pin(which, 1'b0);
            repeat (half - 1) @(posedge aclk);
        end
    endtask
endmodule

// file: tb/digital_phase_loop_ref_feedback_dividers_tb.sv
// Self-checking bench for the reference and feedback dividers.
// Assumes the checker file and the clock pin model are compiled first.
module digital_phase_loop_ref_feedback_dividers_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'h1;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, ref1, ref2, fbk, rev, rclk, fev, fclk;
    int bad_count = 0, compares = 0, cyc = 0, ref_n = 0, fb_n = 0;
    digital_phase_loop_ref_feedback_dividers dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .reference_input_first(ref1),
        .reference_input_second(ref2), .feedback_clock_input(fbk), .ref_div_event(rev),
        .ref_div_clock(rclk), .fb_div_event(fev), .fb_div_clock(fclk)
    );
    clock_pin_model pins (.aclk(aclk), .reference_input_first(ref1), .feedback_clock_input(fbk),
                          .reference_input_second(ref2));
    always #20 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (rev) ref_n++;
        if (fev) fb_n++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        ref_n = 0;
        fb_n = 0;
    endtask
    task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [3:0] st, input logic [1:0] er);
        logic a;
        logic w;
        a = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        awaddr <= {idx[9:0], 2'b00};
        wdata <= {24'h00_0000, d};
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (a || w) begin
            @(posedge aclk);
            if (a && awready) begin
                a = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [11:0] idx, input logic [7:0] ed, input logic [1:0] er);
        rd_word(idx, 32'(ed), er);
    endtask
    task automatic rd_word(input logic [11:0] idx, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= {idx[9:0], 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
    endtask
    task automatic t_regs();
        for (int i = 0; i < 6; i++) rd(digital_phase_loop_div_pkg::REF_DIV_LOW_IDX + 12'(i), 8'h00, 2'h0);
        rd(digital_phase_loop_div_pkg::REF_SELECT_IDX, 8'h00, 2'h0);
        wr(digital_phase_loop_div_pkg::DIV_STATUS_IDX, 8'hFF, 4'h1, 2'h0);
        rd(digital_phase_loop_div_pkg::DIV_STATUS_IDX, 8'h00, 2'h0);
        wr(12'h0FF, 8'h5A, 4'h1, digital_phase_loop_div_pkg::RESP_SLVERR);
        rd(12'h0FF, 8'h00, digital_phase_loop_div_pkg::RESP_SLVERR);
        wr(digital_phase_loop_div_pkg::REF_DIV_CTRL_IDX, 8'hFF, 4'h1, 2'h0);
        rd(digital_phase_loop_div_pkg::REF_DIV_CTRL_IDX, 8'h81, 2'h0);
        wr(digital_phase_loop_div_pkg::FB_DIV_CTRL_IDX, 8'hFF, 4'h1, 2'h0);
        rd(digital_phase_loop_div_pkg::FB_DIV_CTRL_IDX, 8'h81, 2'h0);
        for (int i = 0; i < 5; i++) wr(digital_phase_loop_div_pkg::REF_DIV_LOW_IDX + 12'(i), 8'hFF, 4'h1, 2'h0);
        wr(digital_phase_loop_div_pkg::FB_DIV_LOW_IDX, 8'h00, 4'h0, 2'h0);
        rd(digital_phase_loop_div_pkg::FB_DIV_LOW_IDX, 8'hFF, 2'h0);
        rd(digital_phase_loop_div_pkg::REF_DIV_HIGH_IDX, 8'hFF, 2'h0);
    endtask
    task automatic div_run(input int which, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] ctl,
                           input int edges, input int half, input int exp);
        logic [11:0] base;
        logic [31:0] sv;
        base = (which == 1) ? digital_phase_loop_div_pkg::FB_DIV_LOW_IDX : digital_phase_loop_div_pkg::REF_DIV_LOW_IDX;
        do_reset();
        wr(base, lo, 4'h1, 2'h0);
        wr(base + 12'h001, hi, 4'h1, 2'h0);
        wr(base + 12'h002, ctl, 4'h1, 2'h0);
        wr(digital_phase_loop_div_pkg::REF_SELECT_IDX, (which == 2) ? 8'h01 : 8'h00, 4'h1, 2'h0);
        pins.pulses(which, edges, half);
        repeat (8) @(posedge aclk);
        chk(32'((which == 1) ? fb_n : ref_n), 32'(exp));
        chk(32'((which == 1) ? fclk : rclk), 32'(exp % 2));
        if (which == 1) begin
            sv = 32'((exp << digital_phase_loop_div_pkg::STAT_FB_CNT_LSB) | ((exp % 2) << digital_phase_loop_div_pkg::STAT_FB_LVL_BIT));
        end else begin
            sv = 32'((exp << digital_phase_loop_div_pkg::STAT_REF_CNT_LSB) | ((exp % 2) << digital_phase_loop_div_pkg::STAT_REF_LVL_BIT));
        end
        rd_word(digital_phase_loop_div_pkg::DIV_STATUS_IDX, sv, 2'h0);
    endtask
    task automatic inv_run(input int which);
        do_reset();
        wr((which == 1) ? digital_phase_loop_div_pkg::FB_DIV_CTRL_IDX : digital_phase_loop_div_pkg::REF_DIV_CTRL_IDX, 8'h80, 4'h1, 2'h0);
        repeat (8) @(posedge aclk);
        ref_n = 0;
        fb_n = 0;
        pins.set_pin(which, 1'b1);
        repeat (8) @(posedge aclk);
        chk(32'(ref_n + fb_n), 32'h0);
        pins.set_pin(which, 1'b0);
        repeat (8) @(posedge aclk);
        chk(32'(ref_n + fb_n), 32'h1);
    endtask
    // Ratios stay small and pins slow, so no prescaler is demanded.
    initial begin
        do_reset();
        t_regs();
        div_run(0, 8'h00, 8'h00, 8'h00, 3, 2, 3);
        div_run(1, 8'h00, 8'h00, 8'h00, 3, 7, 3);
        div_run(0, 8'h02, 8'h01, 8'h00, 518, 2, 2);
        div_run(1, 8'h02, 8'h00, 8'h00, 6, 7, 2);
        div_run(0, 8'h01, 8'h00, 8'h01, 8, 2, 2);
        div_run(1, 8'h01, 8'h00, 8'h01, 8, 2, 2);
        div_run(0, 8'h00, 8'h00, 8'h7E, 2, 3, 2);
        div_run(2, 8'h01, 8'h00, 8'h00, 4, 2, 2);
        inv_run(0);
        inv_run(1);
        test_done();
    end
endmodule
